// file: verilog/scirq_defs.vh
// Register map, field positions and timing counts for the card interrupt and supply block
`ifndef SCIRQ_DEFS_VH
`define SCIRQ_DEFS_VH
`define SCIRQ_ADDR_W 16
`define SCIRQ_OFF_STATUS 16'hfe01
`define SCIRQ_OFF_ENABLE 16'hfe02
`define SCIRQ_OFF_SUPPLY 16'hfe03
`define SCIRQ_OFF_TIMER 16'hfe04
`define SCIRQ_OFF_TXCS 16'hfe06
`define SCIRQ_OFF_RXCS 16'hfe07
`define SCIRQ_ENABLE_RST 8'h00
`define SCIRQ_SUPPLY_RST 8'h00
`define SCIRQ_TIMER_RST 4'hf
`define SCIRQ_B_WAIT 7
`define SCIRQ_B_CARD 6
`define SCIRQ_B_STMR 5
`define SCIRQ_B_RX 4
`define SCIRQ_B_TXEV 3
`define SCIRQ_B_TXDN 2
`define SCIRQ_B_TXF 1
`define SCIRQ_B_RXF 0
`define SCIRQ_S_SEL_HI 7
`define SCIRQ_S_SEL_LO 6
`define SCIRQ_S_FAULT 5
`define SCIRQ_S_RDY 4
`define SCIRQ_S_GOOD 3
`define SCIRQ_S_PD 0
`define SCIRQ_TICK_HZ 32768
`define SCIRQ_TICK_NS_X10 305
`define SCIRQ_CLK_HZ 125000000
`define SCIRQ_TICK_CYC (`SCIRQ_CLK_HZ / `SCIRQ_TICK_HZ)
`endif

// file: verilog/scirq_top.v
// Card interrupt status/enable and card supply control
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`include "scirq_defs.vh"
module scirq_top #(
  parameter TICK_CYC = `SCIRQ_TICK_CYC,
  parameter DEACT_CYC = 4
)(
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output wire card_irq,
  input wire sync_mode,
  input wire clock_stop_mode,
  input wire uart_bypass,
  input wire t0_mode,
  input wire break_detect_en,
  input wire wait_timeout,
  input wire length_max,
  input wire length_terminal,
  input wire card_detect_pin,
  input wire iface_fault,
  input wire rx_fifo_not_empty,
  input wire card_io_pin,
  input wire tx_fifo_empty,
  input wire tx_fifo_full,
  input wire tx_byte_sent,
  input wire break_detected,
  input wire tx_underrun,
  input wire rx_overrun,
  input wire rx_parity_err,
  input wire supply_good_pin,
  input wire core_supply_fault_pin,
  output reg [1:0] supply_level,
  output reg activate,
  output reg lines_active,
  output wire iface_power_down
);
  localparam ST_OFF = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_ON = 2'h2;
  localparam ST_DEACT = 2'h3;

  // Pins from outside pass two flops before use
  // I/O line idles high, so its stages reset high: no false falling edge after reset
  reg [2:0] sync1;
  reg [2:0] sync2;
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1 <= 3'h4;
      sync2 <= 3'h4;
    end
    else if (clk_en)
    begin
      sync1 <= {card_io_pin, supply_good_pin, core_supply_fault_pin};
      sync2 <= sync1;
    end
  end
  wire io_s = sync2[2];
  wire good_s = sync2[1];
  wire vfault_s = sync2[0];

  // Card path ignores the clock enable, so insertion is seen while the logic is stopped
  reg [1:0] card_sync1;
  reg [1:0] card_sync2;
  reg det_d;
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      card_sync1 <= 2'h0;
      card_sync2 <= 2'h0;
      det_d <= 1'b0;
    end
    else
    begin
      card_sync1 <= {card_detect_pin, iface_fault};
      card_sync2 <= card_sync1;
      det_d <= card_sync2[1];
    end
  end
  wire det_s = card_sync2[1];
  wire ifault_s = card_sync2[0];

  reg io_d;
  reg good_d;
  reg txe_d;
  reg txf_d;
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      io_d <= 1'b1;
      good_d <= 1'b0;
      txe_d <= 1'b0;
      txf_d <= 1'b0;
    end
    else if (clk_en)
    begin
      io_d <= io_s;
      good_d <= good_s;
      txe_d <= tx_fifo_empty;
      txf_d <= tx_fifo_full;
    end
  end

  wire rd_status = reg_rd && (reg_addr == `SCIRQ_OFF_STATUS);
  wire rd_txcs = reg_rd && (reg_addr == `SCIRQ_OFF_TXCS);
  wire rd_rxcs = reg_rd && (reg_addr == `SCIRQ_OFF_RXCS);
  wire wr_enable = reg_wr && (reg_addr == `SCIRQ_OFF_ENABLE);
  wire wr_supply = reg_wr && (reg_addr == `SCIRQ_OFF_SUPPLY);
  wire wr_timer = reg_wr && (reg_addr == `SCIRQ_OFF_TIMER);

  reg [7:0] irq_enable;
  reg [1:0] supply_select;
  reg ready_start;
  reg power_down;
  reg [3:0] timer_load;
  reg [1:0] state;
  reg [3:0] tick_count;
  reg [31:0] div_count;
  reg [7:0] deact_count;
  reg timer_expired_ev;

  wire card_ev = (det_s != det_d) || ifault_s;
  wire good_lost = good_d && !good_s && (state != ST_OFF);
  wire wait_ev = (clock_stop_mode ? length_terminal : (sync_mode ? length_max : wait_timeout));
  wire rx_edge = io_d && !io_s;
  wire txev_ev = (tx_fifo_empty && !txe_d) || (tx_fifo_full && !txf_d);
  wire txdn_ev = tx_byte_sent && !(t0_mode && break_detect_en && break_detected);
  wire txf_ev = break_detected || tx_underrun;
  wire rxf_ev = rx_overrun || rx_parity_err;

  wire [7:0] status;
  reg flag_wait;
  reg card_flag;
  reg flag_stmr;
  reg flag_rx;
  reg flag_txev;
  reg flag_txdn;
  reg flag_txf;
  reg flag_rxf;

  assign status[`SCIRQ_B_WAIT] = flag_wait;
  assign status[`SCIRQ_B_CARD] = card_flag;
  assign status[`SCIRQ_B_STMR] = flag_stmr;
  assign status[`SCIRQ_B_RX] = flag_rx;
  assign status[`SCIRQ_B_TXEV] = flag_txev;
  assign status[`SCIRQ_B_TXDN] = flag_txdn;
  assign status[`SCIRQ_B_TXF] = flag_txf;
  assign status[`SCIRQ_B_RXF] = flag_rxf;

  // Card flag runs without the clock enable; a read while frozen is not taken, so it cannot clear
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      card_flag <= 1'b0;
    else
      card_flag <= card_ev | (card_flag & ~(rd_status & clk_en));
  end

  // Set beats clear when both land in one cycle
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      flag_wait <= 1'b0;
      flag_stmr <= 1'b0;
      flag_rx <= 1'b0;
      flag_txev <= 1'b0;
      flag_txdn <= 1'b0;
      flag_txf <= 1'b0;
      flag_rxf <= 1'b0;
    end
    else if (clk_en)
    begin
      flag_wait <= wait_ev | (flag_wait & ~rd_status);
      flag_stmr <= timer_expired_ev | (flag_stmr & ~rd_status);
      if (uart_bypass)
      begin
        flag_rx <= rx_edge | (flag_rx & ~rd_status);
      end
      else
      begin
        flag_rx <= rx_fifo_not_empty;
      end
      flag_txev <= txev_ev | (flag_txev & ~rd_txcs);
      flag_txdn <= txdn_ev | (flag_txdn & ~rd_status);
      flag_txf <= txf_ev | (flag_txf & ~rd_txcs);
      flag_rxf <= rxf_ev | (flag_rxf & ~rd_rxcs);
    end
  end

  // Bit 7 of the enable serves wait or length interrupt alike
  assign card_irq = |(status & irq_enable);
  assign iface_power_down = power_down;

  wire sel_nonzero = (reg_wdata[`SCIRQ_S_SEL_HI:`SCIRQ_S_SEL_LO] != 2'h0);
  // Zero field means no timeout, so only ready start can carry activation
  wire timer_none = (timer_load == 4'h0);
  wire tick_now = (div_count == TICK_CYC - 1);
  wire timer_done = !timer_none && tick_now && (tick_count == timer_load - 4'h1);

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_enable <= `SCIRQ_ENABLE_RST;
      supply_select <= 2'h0;
      ready_start <= 1'b0;
      power_down <= 1'b0;
      timer_load <= `SCIRQ_TIMER_RST;
      state <= ST_OFF;
      tick_count <= 4'h0;
      div_count <= 32'h0;
      deact_count <= 8'h00;
      timer_expired_ev <= 1'b0;
      supply_level <= 2'h0;
      activate <= 1'b0;
      lines_active <= 1'b0;
    end
    else if (clk_en)
    begin
      timer_expired_ev <= 1'b0;
      if (wr_enable)
        irq_enable <= reg_wdata;
      if (wr_timer)
        timer_load <= reg_wdata[3:0];
      if (wr_supply)
      begin
        supply_select <= reg_wdata[`SCIRQ_S_SEL_HI:`SCIRQ_S_SEL_LO];
        ready_start <= reg_wdata[`SCIRQ_S_RDY];
        power_down <= reg_wdata[`SCIRQ_S_PD];
      end
      if (vfault_s)
        supply_select <= 2'h0;
      case (state)
        ST_OFF:
        begin
          activate <= 1'b0;
          lines_active <= 1'b0;
          supply_level <= 2'h0;
          tick_count <= 4'h0;
          div_count <= 32'h0;
          // Write-time start; both bits arrive in one write
          if (wr_supply && sel_nonzero && !vfault_s)
          begin
            state <= ST_WAIT;
            supply_level <= reg_wdata[`SCIRQ_S_SEL_HI:`SCIRQ_S_SEL_LO];
          end
        end
        ST_WAIT:
        begin
          if (tick_now)
          begin
            div_count <= 32'h0;
            if (!timer_none)
              tick_count <= tick_count + 4'h1;
          end
          else
            div_count <= div_count + 32'h1;
          if (vfault_s || supply_select == 2'h0)
          begin
            state <= ST_DEACT;
            deact_count <= 8'h00;
          end
          else if (ready_start && good_s)
          begin
            state <= ST_ON;
            activate <= 1'b1;
            lines_active <= 1'b1;
          end
          else if (timer_done)
          begin
            timer_expired_ev <= 1'b1;
            if (good_s)
            begin
              state <= ST_ON;
              activate <= 1'b1;
              lines_active <= 1'b1;
            end
            else
            begin
              // Supply never came good: forced off
              state <= ST_DEACT;
              deact_count <= 8'h00;
              supply_select <= 2'h0;
            end
          end
        end
        ST_ON:
        begin
          if (card_ev || good_lost || vfault_s || supply_select == 2'h0)
          begin
            state <= ST_DEACT;
            deact_count <= 8'h00;
            lines_active <= 1'b0;
          end
        end
        ST_DEACT:
        begin
          activate <= 1'b0;
          lines_active <= 1'b0;
          // Supply stays on until lines have settled low
          if (deact_count == DEACT_CYC[7:0])
          begin
            supply_level <= 2'h0;
            if (supply_select == 2'h0)
              state <= ST_OFF;
          end
          else
            deact_count <= deact_count + 8'h01;
        end
        default:
          state <= ST_OFF;
      endcase
    end
  end

  // Fault bit reads 1 while the core supply is sound
  wire [7:0] supply_rd = {supply_select, ~vfault_s, ready_start, good_s, 2'b00, power_down};

  // UART control/status addresses only clear flags here and read back as zero

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (clk_en)
    begin
      if (reg_rd)
      begin
        case (reg_addr)
          `SCIRQ_OFF_STATUS: reg_rdata <= status;
          `SCIRQ_OFF_ENABLE: reg_rdata <= irq_enable;
          `SCIRQ_OFF_SUPPLY: reg_rdata <= supply_rd;
          `SCIRQ_OFF_TIMER: reg_rdata <= {4'h0, timer_load};
          default: reg_rdata <= 8'h00;
        endcase
      end
      else
        reg_rdata <= 8'h00;
    end
  end
endmodule

// file: test/scirq_top_sva.sv
// Port-level assertions for the card interrupt and supply block
`timescale 1ns/100ps
module scirq_sva (
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire card_irq,
  input wire uart_bypass,
  input wire rx_fifo_not_empty,
  input wire rx_overrun,
  input wire tx_underrun,
  input wire core_supply_fault_pin,
  input wire [1:0] supply_level,
  input wire lines_active,
  input wire iface_power_down
);
  reg [7:0] en;
  wire we = clk_en && reg_wr;
  wire idle = clk_en && !reg_wr;
  // Shadow of the enable register, rebuilt from bus writes alone
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      en <= 8'h00;
    else if (we && reg_addr == 16'hfe02)
      en <= reg_wdata;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  en_off_a: assert property (en == 8'h00 |-> !card_irq)
    else $error("interrupt raised with every enable off");
  rx_level_a: assert property ((idle && en[4] && !uart_bypass && rx_fifo_not_empty) [*2] |-> card_irq)
    else $error("rx pending did not interrupt");
  rx_clear_a: assert property ((idle && en == 8'h10 && !uart_bypass && !rx_fifo_not_empty) [*3] |-> !card_irq)
    else $error("rx pending stayed with empty fifo");
  rx_fault_a: assert property (idle && en[0] && rx_overrun |=> card_irq)
    else $error("overrun did not interrupt");
  tx_fault_a: assert property (idle && en[1] && tx_underrun |=> card_irq)
    else $error("underrun did not interrupt");
  pd_bit_a: assert property (we && reg_addr == 16'hfe03 |=> iface_power_down == $past(reg_wdata[0]))
    else $error("power down bit not applied");
  supply_last_a: assert property (supply_level == 2'b00 && $past(supply_level) != 2'b00 |-> !$past(lines_active))
    else $error("supply removed while lines active");
  fault_off_a: assert property (core_supply_fault_pin [*3] |-> ##[0:100] supply_level == 2'b00)
    else $error("core fault did not remove supply");
  cover property ($rose(card_irq));
  cover property ($fell(lines_active));
  cover property (supply_level == 2'b11);
endmodule
bind scirq_top scirq_sva chk_u (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .card_irq(card_irq), .uart_bypass(uart_bypass),
  .rx_fifo_not_empty(rx_fifo_not_empty), .rx_overrun(rx_overrun), .tx_underrun(tx_underrun),
  .core_supply_fault_pin(core_supply_fault_pin), .supply_level(supply_level), .lines_active(lines_active),
  .iface_power_down(iface_power_down));

// file: test/scirq_supply_model.sv
// Behavioural card supply regulator answering the applied supply level
`timescale 1ns/100ps
module scirq_supply_model #(
  parameter RISE_CYC = 6
)(
  input wire core_clk,
  input wire [1:0] supply_level,
  output reg supply_good_pin
);
  integer n = 0;
  initial supply_good_pin = 1'b0;
  // Good only once the rail has settled, lost at once when removed
  always @(posedge core_clk)
  begin
    n <= (supply_level == 2'b00) ? 0 : n + 1;
    supply_good_pin <= (supply_level != 2'b00) && (n >= RISE_CYC);
  end
endmodule

// file: test/test_scirq_top.sv
// Self-checking bench for the card interrupt and supply block
`timescale 1ns/100ps
module test_scirq_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [11:0] src = 12'h000;
  logic uart_bypass = 1'b0;
  logic card_io_pin = 1'b1;
  logic rx_fifo_not_empty = 1'b0;
  logic core_supply_fault_pin = 1'b0;
  logic clk_en = 1'b1;
  logic sync_mode = 1'b0;
  logic clock_stop_mode = 1'b0;
  logic length_max = 1'b0;
  logic length_terminal = 1'b0;
  logic [7:0] reg_rdata;
  logic card_irq;
  logic supply_good_pin;
  logic [1:0] supply_level;
  logic activate;
  logic lines_active;
  logic iface_power_down;
  int miscompares = 0;
  int total_checks = 0;
  // Source pulses and the status they leave; last entry is a break at byte end
  logic [11:0] pat [0:10] = '{12'h001, 12'h002, 12'h004, 12'h008, 12'h010, 12'h020, 12'h040, 12'h080,
    12'h100, 12'h200, 12'hc60};
  logic [7:0] want [0:10] = '{8'h80, 8'h40, 8'h40, 8'h08, 8'h08, 8'h04, 8'h02, 8'h02, 8'h01, 8'h01, 8'h02};
  always #4 core_clk = ~core_clk;
  scirq_top #(.TICK_CYC(4), .DEACT_CYC(4)) dut_u (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .card_irq(card_irq), .sync_mode(sync_mode), .clock_stop_mode(clock_stop_mode), .uart_bypass(uart_bypass),
    .t0_mode(src[10]), .break_detect_en(src[11]), .wait_timeout(src[0]), .length_max(length_max),
    .length_terminal(length_terminal), .card_detect_pin(src[1]), .iface_fault(src[2]),
    .rx_fifo_not_empty(rx_fifo_not_empty), .card_io_pin(card_io_pin), .tx_fifo_empty(src[3]),
    .tx_fifo_full(src[4]), .tx_byte_sent(src[5]), .break_detected(src[6]), .tx_underrun(src[7]),
    .rx_overrun(src[8]), .rx_parity_err(src[9]), .supply_good_pin(supply_good_pin),
    .core_supply_fault_pin(core_supply_fault_pin), .supply_level(supply_level), .activate(activate),
    .lines_active(lines_active), .iface_power_down(iface_power_down));
  scirq_supply_model supply_u (.core_clk(core_clk), .supply_level(supply_level),
    .supply_good_pin(supply_good_pin));
  task automatic finish_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic pulse(input logic [11:0] p);
    @(posedge core_clk);
    src <= p;
    @(posedge core_clk);
    src <= 12'h000;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic wait_level(input logic [1:0] v);
    int i;
    for (i = 0; i < 200 && supply_level !== v; i++)
      @(posedge core_clk);
    chk({6'h00, supply_level}, {6'h00, v});
  endtask
  task automatic t_regs;
    rd(16'hfe02, 8'h00);
    rd(16'hfe03, 8'h20);
    rd(16'hfe04, 8'h0f);
    rd(16'hfe0f, 8'h00);
    wr(16'hfe01, 8'hff);
    rd(16'hfe01, 8'h00);
    wr(16'hfe02, 8'ha5);
    rd(16'hfe02, 8'ha5);
    wr(16'hfe03, 8'h01);
    rd(16'hfe03, 8'h21);
    wr(16'hfe03, 8'h00);
  endtask
  task automatic t_src;
    int i;
    wr(16'hfe02, 8'hff);
    for (i = 0; i < 11; i++)
    begin
      pulse(pat[i]);
      rd(16'hfe01, want[i]);
      rd(16'hfe06, 8'h00);
      rd(16'hfe07, 8'h00);
      rd(16'hfe01, 8'h00);
    end
    wr(16'hfe02, 8'h00);
  endtask
  task automatic t_irq;
    wr(16'hfe02, 8'h80);
    pulse(12'h001);
    chk({7'h00, card_irq}, 8'h01);
    rd(16'hfe01, 8'h80);
    chk({7'h00, card_irq}, 8'h00);
    clk_en <= 1'b0;
    pulse(12'h003);
    clk_en <= 1'b1;
    rd(16'hfe01, 8'h40);
  endtask
  task automatic t_sync;
    wr(16'hfe02, 8'h80);
    sync_mode <= 1'b1;
    pulse(12'h001);
    rd(16'hfe01, 8'h00);
    length_max <= 1'b1;
    @(posedge core_clk);
    length_max <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({7'h00, card_irq}, 8'h01);
    rd(16'hfe01, 8'h80);
    clock_stop_mode <= 1'b1;
    length_terminal <= 1'b1;
    @(posedge core_clk);
    length_terminal <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(16'hfe01, 8'h80);
    sync_mode <= 1'b0;
    clock_stop_mode <= 1'b0;
    wr(16'hfe02, 8'h00);
  endtask
  task automatic t_rx;
    wr(16'hfe02, 8'h10);
    rx_fifo_not_empty <= 1'b1;
    pulse(12'h100);
    rd(16'hfe01, 8'h11);
    chk({7'h00, card_irq}, 8'h01);
    rx_fifo_not_empty <= 1'b0;
    rd(16'hfe07, 8'h00);
    rd(16'hfe01, 8'h00);
    uart_bypass <= 1'b1;
    card_io_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(16'hfe01, 8'h10);
    rd(16'hfe01, 8'h00);
    uart_bypass <= 1'b0;
    card_io_pin <= 1'b1;
    wr(16'hfe02, 8'h00);
  endtask
  task automatic t_supply;
    int v;
    for (v = 1; v < 4; v++)
    begin
      wr(16'hfe03, {v[1:0], 6'h00});
      wait_level(v[1:0]);
      repeat (80) @(posedge core_clk);
      chk({6'h00, activate, lines_active}, 8'h03);
      rd(16'hfe01, 8'h20);
      wr(16'hfe03, 8'h00);
      wait_level(2'b00);
      chk({6'h00, activate, lines_active}, 8'h00);
    end
    wr(16'hfe04, 8'h00);
    wr(16'hfe03, 8'h50);
    repeat (20) @(posedge core_clk);
    chk({6'h00, activate, lines_active}, 8'h03);
    pulse(12'h002);
    wait_level(2'b00);
    repeat (4) @(posedge core_clk);
    rd(16'hfe03, 8'h70);
    rd(16'hfe01, 8'h40);
    wr(16'hfe03, 8'h00);
    wr(16'hfe04, 8'h0f);
    wr(16'hfe03, 8'hc0);
    wait_level(2'b11);
    core_supply_fault_pin <= 1'b1;
    wait_level(2'b00);
    repeat (4) @(posedge core_clk);
    rd(16'hfe03, 8'h00);
    core_supply_fault_pin <= 1'b0;
    wr(16'hfe03, 8'h00);
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_src;
    t_irq;
    t_sync;
    t_rx;
    t_supply;
    finish_test;
  end
  // Whole run is under a thousand cycles; this only cuts a hang
  initial
  begin
    #100000;
    miscompares++;
    finish_test;
  end
endmodule
